/* File: pfol_pkg.sv */
// constants, types and register map of the protective field output logic
// Operation
// - two independent functions drive groups A and B
// - at most ten field pairs per bank
// - outside four-field mode each bank selects its field pair independently
// - four-field mode: one protective, three warning fields
// - four-field mode: B pair follows A pair
// - four-field mode: A protective violation switches A
// - four-field mode: B violation only raises indication
// - logic signals routed to outputs by configuration
// - separate warning indications for A and B
// - per-bank resolution from 30 to 150 mm
// - per-bank maximum vehicle speed for mobile use
// - outputs off within configured response time
// - response time, start-up behaviour set per bank
// - automatic mode enables at start and clear
// - start interlock keeps outputs off after supply
// - start interlock restarts automatically after violation
// - interlock releases only on reset button press
// - restart interlock holds off until button press
package pfol_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NUM_PAIRS = 10;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BANK_A = 8'h04;
    localparam logic [7:0] ADDR_BANK_B = 8'h08;
    localparam logic [7:0] ADDR_ROUTE = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // bank register fields
    localparam int BANK_START_LSB = 0;
    localparam int BANK_RESOL_LSB = 2;
    localparam int BANK_SPEED_LSB = 8;
    localparam int BANK_RESP_LSB = 16;
    localparam logic [2:0] RESOL_MAX = 3'h5;
    localparam logic [1:0] START_AUTO = 2'h0;
    localparam logic [1:0] START_LOCK_AUTO = 2'h1;
    localparam logic [1:0] START_RES_LOCK = 2'h2;
    localparam logic [1:0] START_RST = 2'h2;
    localparam logic [2:0] RESOL_RST = 3'h0;
    localparam logic [7:0] SPEED_RST = 8'h00;
    localparam logic [15:0] RESP_RST = 16'h0050;

    // route register fields and sources
    localparam int ROUTE_MSG_LSB = 0;
    localparam int ROUTE_AUX_LSB = 4;
    localparam int ROUTE_INOUT_LSB = 8;
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_PF_B = 3'h1;
    localparam logic [2:0] SRC_WF_A = 3'h2;
    localparam logic [2:0] SRC_WF_B = 3'h3;
    localparam logic [2:0] SRC_SAFE_A = 3'h4;
    localparam logic [2:0] SRC_SAFE_B = 3'h5;

    typedef enum logic [3:0] {
        ST_START_LOCK = 4'h1,
        ST_RUN = 4'h2,
        ST_TRIP = 4'h4,
        ST_RESTART_LOCK = 4'h8
    } pfol_state_t;

endpackage

/* File: pfol_channel.sv */
// one protective function: start-up behaviour, restart and response time
`timescale 1ns/1ps
module pfol_channel
    import pfol_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // conditions
    input wire logic i_tick,
    input wire logic i_enable,
    input wire logic i_supply_ok,
    input wire logic i_press,
    input wire logic i_pf_vio,
    input wire logic i_fault,
    // bank settings
    input wire logic [1:0] i_start_mode,
    input wire logic [15:0] i_resp_us,
    // results
    output logic o_safe,
    output logic o_locked
);

    pfol_state_t state;
    pfol_state_t next_state;
    logic [15:0] vio_us;
    logic [15:0] next_vio_us;
    logic next_safe;
    logic clear;
    logic trip;
    logic restart_free;

    always_comb
    begin
        clear = !i_pf_vio && !i_fault;
        // illegal mode code 3 falls back to full interlock
        restart_free = (i_start_mode == START_AUTO) || (i_start_mode == START_LOCK_AUTO);
        trip = i_fault || (i_pf_vio && ((i_resp_us == 16'h0000) ||
               (i_tick && ({1'b0, vio_us} + 17'h00001 >= {1'b0, i_resp_us}))));
        next_state = state;
        if (!i_supply_ok)
        begin
            next_state = ST_START_LOCK;
        end
        else
        begin
            unique case (state)
                ST_START_LOCK:
                begin
                    if (clear && ((i_start_mode == START_AUTO) || i_press))
                    begin
                        next_state = ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    if (trip)
                    begin
                        next_state = ST_TRIP;
                    end
                end
                ST_TRIP:
                begin
                    if (clear)
                    begin
                        next_state = restart_free ? ST_RUN : ST_RESTART_LOCK;
                    end
                end
                ST_RESTART_LOCK:
                begin
                    if (clear && i_press)
                    begin
                        next_state = ST_RUN;
                    end
                end
            endcase
        end
        next_vio_us = 16'h0000;
        if (state == ST_RUN && i_pf_vio && !trip)
        begin
            next_vio_us = i_tick ? vio_us + 16'h0001 : vio_us;
        end
        next_safe = (next_state == ST_RUN) && i_enable;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state <= ST_START_LOCK;
            vio_us <= 16'h0000;
            o_safe <= 1'b0;
            o_locked <= 1'b0;
        end
        else
        begin
            state <= next_state;
            vio_us <= next_vio_us;
            o_safe <= next_safe;
            o_locked <= (next_state == ST_START_LOCK) || (next_state == ST_RESTART_LOCK);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    logic [15:0] watch_us;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            watch_us <= 16'h0000;
        end
        else if (o_safe && i_pf_vio)
        begin
            watch_us <= i_tick ? watch_us + 16'h0001 : watch_us;
        end
        else
        begin
            watch_us <= 16'h0000;
        end
    end

    a_resp_bound: assert property ((o_safe && i_pf_vio && $stable(i_resp_us)) |->
        (watch_us <= i_resp_us)) else $error("violation outlived response time");
    a_auto_start: assert property ((state == ST_START_LOCK && i_supply_ok && clear &&
        i_start_mode == START_AUTO && i_enable) |=> o_safe)
        else $error("automatic start did not enable");
    a_start_hold: assert property ((state == ST_START_LOCK && i_start_mode != START_AUTO
        && !i_press) |=> !o_safe) else $error("start interlock released without press");
    a_auto_restart: assert property ((state == ST_TRIP && clear && i_supply_ok && i_enable
        && i_start_mode == START_LOCK_AUTO) |=> o_safe)
        else $error("automatic restart missing");
    a_restart_hold: assert property ((state == ST_TRIP && i_start_mode == START_RES_LOCK)
        |=> !o_safe ##1 (!o_safe || $past(i_press))) else $error("restart lock released");
    a_press_release: assert property ((state == ST_RESTART_LOCK && i_press && clear &&
        i_supply_ok && i_enable) |=> o_safe) else $error("press did not release lock");

    c_trip: cover property (o_safe ##1 !o_safe ##[1:20] o_safe);
    c_restart_lock: cover property (state == ST_RESTART_LOCK ##[1:20] o_safe);

endmodule

/* File: pfol_top.sv */
// field violation evaluation, output routing and configuration registers
`timescale 1ns/1ps
module pfol_top
    import pfol_pkg::*;
(
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    // register port
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [31:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [31:0] O_REG_RDATA,
    // field evaluation results and pair selection
    input wire logic [9:0] I_PF_VIO_A,
    input wire logic [9:0] I_WF_VIO_A,
    input wire logic [9:0] I_PF_VIO_B,
    input wire logic [9:0] I_WF_VIO_B,
    input wire logic [3:0] I_FP_SEL_A,
    input wire logic [3:0] I_FP_SEL_B,
    // pins
    input wire logic I_RESTART_BUTTON,
    input wire logic I_SUPPLY_OK,
    input wire logic I_AUX_INOUT_ONE,
    // outputs
    output logic O_SAFE_OUTPUT_GROUP_A,
    output logic O_SAFE_OUTPUT_GROUP_B,
    output logic O_WARNING_VIOLATION_A,
    output logic O_WARNING_VIOLATION_B,
    output logic O_PF_B_INDICATION,
    output logic O_UNSAFE_MESSAGE_OUTPUT,
    output logic O_AUX_OUTPUT_ONE,
    output logic O_AUX_INOUT_ONE,
    output logic O_AUX_INOUT_ONE_OE
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic pick_pair(input logic [9:0] vec, input logic [3:0] idx);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_PAIRS; i++)
        begin
            if (idx == 4'(i))
            begin
                hit = vec[i];
            end
        end
        return hit;
    endfunction

    function automatic logic pair_bad(input logic [3:0] idx);
        return idx >= 4'(NUM_PAIRS);
    endfunction

    function automatic logic route_pick(input logic [2:0] src, input logic [5:0] sigs);
        logic val;
        val = 1'b0;
        if (src != SRC_NONE && src <= SRC_SAFE_B)
        begin
            val = sigs[src];
        end
        return val;
    endfunction

    // ****************************************
    // pin synchronisers and button edge
    // ****************************************
    logic [1:0] btn_sync;
    logic [1:0] sup_sync;
    logic [1:0] aux_sync;
    logic btn_prev;
    logic press;
    logic next_press;

    always_comb
    begin
        next_press = btn_sync[1] && !btn_prev;
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            // held high so a button already down at release is not taken as a press
            btn_sync <= 2'h3;
            sup_sync <= 2'h0;
            aux_sync <= 2'h0;
            btn_prev <= 1'b1;
            press <= 1'b0;
        end
        else
        begin
            btn_sync <= {btn_sync[0], I_RESTART_BUTTON};
            sup_sync <= {sup_sync[0], I_SUPPLY_OK};
            aux_sync <= {aux_sync[0], I_AUX_INOUT_ONE};
            btn_prev <= btn_sync[1];
            press <= next_press;
        end
    end

    // ****************************************
    // microsecond tick
    // ****************************************
    logic [7:0] div_cnt;
    logic [7:0] next_div_cnt;
    logic tick;
    logic next_tick;

    always_comb
    begin
        next_tick = (div_cnt == 8'(TICK_CYC - 1));
        next_div_cnt = next_tick ? 8'h00 : div_cnt + 8'h01;
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            div_cnt <= 8'h00;
            tick <= 1'b0;
        end
        else
        begin
            div_cnt <= next_div_cnt;
            tick <= next_tick;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    logic four_field;
    logic [1:0] start_a;
    logic [1:0] start_b;
    logic [2:0] resol_a;
    logic [2:0] resol_b;
    logic [7:0] speed_a;
    logic [7:0] speed_b;
    logic [15:0] resp_a;
    logic [15:0] resp_b;
    logic [11:0] route;
    logic next_four_field;
    logic [1:0] next_start_a;
    logic [1:0] next_start_b;
    logic [2:0] next_resol_a;
    logic [2:0] next_resol_b;
    logic [7:0] next_speed_a;
    logic [7:0] next_speed_b;
    logic [15:0] next_resp_a;
    logic [15:0] next_resp_b;
    logic [11:0] next_route;
    logic [31:0] next_rdata;
    logic [31:0] status;
    logic [2:0] wr_resol;

    always_comb
    begin
        wr_resol = I_REG_WDATA[BANK_RESOL_LSB +: 3];
        next_four_field = four_field;
        next_start_a = start_a;
        next_start_b = start_b;
        next_resol_a = resol_a;
        next_resol_b = resol_b;
        next_speed_a = speed_a;
        next_speed_b = speed_b;
        next_resp_a = resp_a;
        next_resp_b = resp_b;
        next_route = route;
        if (I_REG_WR)
        begin
            // per-bank settings apply to every pair of the bank
            unique case (I_REG_ADDR)
                ADDR_CTRL: next_four_field = I_REG_WDATA[0];
                ADDR_BANK_A:
                begin
                    next_start_a = I_REG_WDATA[BANK_START_LSB +: 2];
                    next_speed_a = I_REG_WDATA[BANK_SPEED_LSB +: 8];
                    next_resp_a = I_REG_WDATA[BANK_RESP_LSB +: 16];
                    // unlisted resolution codes are ignored
                    next_resol_a = (wr_resol <= RESOL_MAX) ? wr_resol : resol_a;
                end
                ADDR_BANK_B:
                begin
                    next_start_b = I_REG_WDATA[BANK_START_LSB +: 2];
                    next_speed_b = I_REG_WDATA[BANK_SPEED_LSB +: 8];
                    next_resp_b = I_REG_WDATA[BANK_RESP_LSB +: 16];
                    next_resol_b = (wr_resol <= RESOL_MAX) ? wr_resol : resol_b;
                end
                ADDR_ROUTE: next_route = I_REG_WDATA[11:0];
                default: next_route = route;
            endcase
        end
        next_rdata = 32'h0000_0000;
        if (I_REG_RD)
        begin
            unique case (I_REG_ADDR)
                ADDR_CTRL: next_rdata = {31'h0000_0000, four_field};
                ADDR_BANK_A: next_rdata = {resp_a, speed_a, 3'h0, resol_a, start_a};
                ADDR_BANK_B: next_rdata = {resp_b, speed_b, 3'h0, resol_b, start_b};
                ADDR_ROUTE: next_rdata = {20'h0_0000, route};
                ADDR_STATUS: next_rdata = status;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            four_field <= 1'b0;
            start_a <= START_RST;
            start_b <= START_RST;
            resol_a <= RESOL_RST;
            resol_b <= RESOL_RST;
            speed_a <= SPEED_RST;
            speed_b <= SPEED_RST;
            resp_a <= RESP_RST;
            resp_b <= RESP_RST;
            route <= {1'b0, SRC_WF_B, 1'b0, SRC_WF_A, 1'b0, SRC_PF_B};
            O_REG_RDATA <= 32'h0000_0000;
        end
        else
        begin
            four_field <= next_four_field;
            start_a <= next_start_a;
            start_b <= next_start_b;
            resol_a <= next_resol_a;
            resol_b <= next_resol_b;
            speed_a <= next_speed_a;
            speed_b <= next_speed_b;
            resp_a <= next_resp_a;
            resp_b <= next_resp_b;
            route <= next_route;
            O_REG_RDATA <= next_rdata;
        end
    end

    // ****************************************
    // field pair evaluation
    // ****************************************
    logic [3:0] sel_b;
    logic pf_a;
    logic pf_b;
    logic fault_a;
    logic fault_b;
    logic locked_a;
    logic locked_b;

    always_comb
    begin
        sel_b = four_field ? I_FP_SEL_A : I_FP_SEL_B;
        pf_a = pick_pair(I_PF_VIO_A, I_FP_SEL_A);
        pf_b = pick_pair(I_PF_VIO_B, sel_b);
        // a pair number past the bank is treated as a fault
        fault_a = pair_bad(I_FP_SEL_A);
        fault_b = pair_bad(sel_b);
    end

    pfol_channel u_chan_a (
        .i_clk(I_CORE_CLK),
        .i_rst_b(I_RST_B),
        .i_tick(tick),
        .i_enable(1'b1),
        .i_supply_ok(sup_sync[1]),
        .i_press(press),
        .i_pf_vio(pf_a),
        .i_fault(fault_a),
        .i_start_mode(start_a),
        .i_resp_us(resp_a),
        .o_safe(O_SAFE_OUTPUT_GROUP_A),
        .o_locked(locked_a)
    );

    // from the second cycle of four-field mode on, function B drives no safe group
    pfol_channel u_chan_b (
        .i_clk(I_CORE_CLK),
        .i_rst_b(I_RST_B),
        .i_tick(tick),
        .i_enable(!four_field),
        .i_supply_ok(sup_sync[1]),
        .i_press(press),
        .i_pf_vio(pf_b),
        .i_fault(fault_b),
        .i_start_mode(start_b),
        .i_resp_us(resp_b),
        .o_safe(O_SAFE_OUTPUT_GROUP_B),
        .o_locked(locked_b)
    );

    // ****************************************
    // indications and routing
    // ****************************************
    logic [5:0] sigs;
    logic next_wf_a;
    logic next_wf_b;
    logic next_pf_b_ind;

    always_comb
    begin
        next_wf_a = pick_pair(I_WF_VIO_A, I_FP_SEL_A);
        next_wf_b = pick_pair(I_WF_VIO_B, sel_b);
        next_pf_b_ind = pf_b || fault_b;
        sigs = {O_SAFE_OUTPUT_GROUP_B, O_SAFE_OUTPUT_GROUP_A, O_WARNING_VIOLATION_B,
                O_WARNING_VIOLATION_A, O_PF_B_INDICATION, 1'b0};
        status = {22'h00_0000, aux_sync[1], sup_sync[1], locked_b, locked_a,
                  O_PF_B_INDICATION, O_WARNING_VIOLATION_B, O_WARNING_VIOLATION_A,
                  O_SAFE_OUTPUT_GROUP_B, O_SAFE_OUTPUT_GROUP_A, fault_a || fault_b};
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            O_WARNING_VIOLATION_A <= 1'b0;
            O_WARNING_VIOLATION_B <= 1'b0;
            O_PF_B_INDICATION <= 1'b0;
            O_UNSAFE_MESSAGE_OUTPUT <= 1'b0;
            O_AUX_OUTPUT_ONE <= 1'b0;
            O_AUX_INOUT_ONE <= 1'b0;
            O_AUX_INOUT_ONE_OE <= 1'b0;
        end
        else
        begin
            O_WARNING_VIOLATION_A <= next_wf_a;
            O_WARNING_VIOLATION_B <= next_wf_b;
            O_PF_B_INDICATION <= next_pf_b_ind;
            O_UNSAFE_MESSAGE_OUTPUT <= route_pick(route[ROUTE_MSG_LSB +: 3], sigs);
            O_AUX_OUTPUT_ONE <= route_pick(route[ROUTE_AUX_LSB +: 3], sigs);
            O_AUX_INOUT_ONE <= route_pick(route[ROUTE_INOUT_LSB +: 3], sigs);
            O_AUX_INOUT_ONE_OE <= route[ROUTE_INOUT_LSB +: 3] != SRC_NONE;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RST_B);

    a_b_group_off: assert property (four_field ##1 four_field |-> !O_SAFE_OUTPUT_GROUP_B)
        else $error("group B driven in four-field mode");
    a_pair_follow: assert property ((four_field && (I_FP_SEL_A < 4'(NUM_PAIRS))) |=>
        O_WARNING_VIOLATION_B == $past(I_WF_VIO_B[I_FP_SEL_A]))
        else $error("B pair not following A pair");
    a_press_once: assert property (press |-> $past(I_RESTART_BUTTON, 3) &&
        !$past(I_RESTART_BUTTON, 4)) else $error("press without button edge");
    a_warn_a: assert property ((I_FP_SEL_A < 4'(NUM_PAIRS)) |=> O_WARNING_VIOLATION_A ==
        $past(I_WF_VIO_A[I_FP_SEL_A])) else $error("warning A wrong");
    a_read_only: assert property (!I_REG_RD |=> O_REG_RDATA == 32'h0000_0000)
        else $error("read data outside read answer");
    a_route_msg: assert property ((route[ROUTE_MSG_LSB +: 3] == SRC_PF_B) ##1
        (route[ROUTE_MSG_LSB +: 3] == SRC_PF_B) |-> O_UNSAFE_MESSAGE_OUTPUT ==
        $past(O_PF_B_INDICATION)) else $error("message output not routed");

    c_four_ind: cover property (four_field && O_PF_B_INDICATION);
    c_both_safe: cover property (O_SAFE_OUTPUT_GROUP_A && O_SAFE_OUTPUT_GROUP_B);

endmodule

/* File: pfol_partner.sv */
// operator reset button model, pressed on request of the bench
`timescale 1ns/1ps
module pfol_partner (
    // clock
    input wire logic i_clk,
    // request from the bench
    input wire logic i_push,
    input wire logic [7:0] i_len,
    // button pin
    output logic o_button
);
    // ****************************************
    // button hold
    // ****************************************
    int count = 0;
    // a real operator holds the button for many cycles, so a held level is the norm
    always @(posedge i_clk)
    begin
        if (i_push)
            count <= i_len;
        else if (count > 0)
            count <= count - 1;
    end
    assign o_button = (count > 0);
endmodule

/* File: tb_protective_field_output_logic.sv */
// self-checking bench of the protective field output logic
`timescale 1ns/1ps
module tb_protective_field_output_logic;
    import pfol_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, supply = 1, aux_in = 1, push = 0, button;
    logic [7:0] addr = 0, len = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [9:0] pf_a = 0, wf_a = 0, pf_b = 0, wf_b = 0;
    logic [3:0] sel_a = 0, sel_b = 0;
    logic safe_a, safe_b, warn_a, warn_b, pfb_ind, msg, aux1, aux_io, aux_oe;
    int miscompares = 0, checked = 0, sa;

    pfol_top dut_u (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
        .I_PF_VIO_A(pf_a), .I_WF_VIO_A(wf_a), .I_PF_VIO_B(pf_b), .I_WF_VIO_B(wf_b),
        .I_FP_SEL_A(sel_a), .I_FP_SEL_B(sel_b), .I_RESTART_BUTTON(button),
        .I_SUPPLY_OK(supply), .I_AUX_INOUT_ONE(aux_in), .O_SAFE_OUTPUT_GROUP_A(safe_a),
        .O_SAFE_OUTPUT_GROUP_B(safe_b), .O_WARNING_VIOLATION_A(warn_a),
        .O_WARNING_VIOLATION_B(warn_b), .O_PF_B_INDICATION(pfb_ind),
        .O_UNSAFE_MESSAGE_OUTPUT(msg), .O_AUX_OUTPUT_ONE(aux1), .O_AUX_INOUT_ONE(aux_io),
        .O_AUX_INOUT_ONE_OE(aux_oe));
    pfol_partner partner_u (.i_clk(clk), .i_push(push), .i_len(len), .o_button(button));

    initial
    begin
        forever #2 clk = ~clk;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic at(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic press(input logic [7:0] l);
        @(posedge clk);
        push <= 1'b1;
        len <= l;
        @(posedge clk);
        push <= 1'b0;
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // bounded run: the sequence needs well under 10 us
    initial
    begin
        #100us;
        miscompares++;
        complete_run();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'h9efb));
        sa = $urandom % NUM_PAIRS;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        sel_a <= 4'(sa);
        sel_b <= 4'(sa);
        rd_reg(ADDR_BANK_A, d);
        chk("bank_a reset", d, 32'h00500002);
        rd_reg(ADDR_ROUTE, d);
        chk("route reset", d, 32'h00000321);
        rd_reg(8'h14, d);
        chk("unmapped", d, 32'h0);
        rd_reg(ADDR_STATUS, d);
        chk("status pins", d[9:8], 2'h3);
        chk("start lock a", safe_a, 1'b0);
        wr_reg(ADDR_BANK_A, 32'h0000001a);
        rd_reg(ADDR_BANK_A, d);
        chk("bad resolution", d, 32'h00000002);
        wr_reg(ADDR_BANK_A, 32'h00003c16);
        rd_reg(ADDR_BANK_A, d);
        chk("bank fields", d, 32'h00003c16);
        wr_reg(ADDR_BANK_B, 32'h00000002);
        // a long press stays held across the following trip
        press(8'hc8);
        at(10);
        chk("press a", safe_a, 1'b1);
        chk("press b", safe_b, 1'b1);
        @(posedge clk);
        pf_a <= 10'h1 << sa;
        at(2);
        chk("trip a", safe_a, 1'b0);
        chk("b independent", safe_b, 1'b1);
        @(posedge clk);
        pf_a <= 10'h0;
        at(20);
        chk("restart lock", safe_a, 1'b0);
        at(200);
        press(8'h04);
        at(10);
        chk("restart press", safe_a, 1'b1);
        @(posedge clk);
        pf_a <= 10'h1 << ((sa + 1) % NUM_PAIRS);
        at(4);
        chk("other pair", safe_a, 1'b1);
        @(posedge clk);
        pf_a <= 10'h0;
        sel_a <= 4'ha;
        at(3);
        chk("pair fault", safe_a, 1'b0);
        @(posedge clk);
        sel_a <= 4'(sa);
        wr_reg(ADDR_BANK_A, 32'h00000001);
        press(8'h04);
        at(10);
        chk("mode1 run", safe_a, 1'b1);
        @(posedge clk);
        pf_a <= 10'h1 << sa;
        at(2);
        chk("mode1 trip", safe_a, 1'b0);
        @(posedge clk);
        pf_a <= 10'h0;
        at(3);
        chk("auto restart", safe_a, 1'b1);
        @(posedge clk);
        supply <= 1'b0;
        at(5);
        chk("supply lost", safe_a, 1'b0);
        @(posedge clk);
        supply <= 1'b1;
        at(20);
        chk("supply back", safe_a, 1'b0);
        press(8'h04);
        at(10);
        chk("supply press", safe_a, 1'b1);
        wr_reg(ADDR_BANK_A, 32'h00020000);
        @(posedge clk);
        supply <= 1'b0;
        at(5);
        @(posedge clk);
        supply <= 1'b1;
        at(20);
        chk("auto start", safe_a, 1'b1);
        @(posedge clk);
        pf_a <= 10'h1 << sa;
        at(240);
        chk("filter holds", safe_a, 1'b1);
        at(270);
        chk("resp limit", safe_a, 1'b0);
        @(posedge clk);
        pf_a <= 10'h0;
        wf_a <= 10'($urandom);
        wf_b <= 10'($urandom);
        at(4);
        chk("auto clear", safe_a, 1'b1);
        chk("warn a", warn_a, wf_a[sa]);
        chk("warn b", warn_b, wf_b[sa]);
        chk("aux one", aux1, wf_a[sa]);
        chk("aux inout", {aux_oe, aux_io}, {1'b1, wf_b[sa]});
        wr_reg(ADDR_ROUTE, 32'h00000004);
        at(3);
        chk("route safe a", {aux_oe, msg}, 2'h1);
        // group B must be running so that the mode switch alone can drop it
        press(8'h04);
        at(10);
        chk("b run", safe_b, 1'b1);
        wr_reg(ADDR_CTRL, 32'h00000001);
        at(2);
        chk("four b off", safe_b, 1'b0);
        @(posedge clk);
        sel_b <= 4'((sa + 3) % NUM_PAIRS);
        pf_b <= 10'h1 << sa;
        at(4);
        chk("b indication", pfb_ind, 1'b1);
        chk("four a kept", safe_a, 1'b1);
        @(posedge clk);
        pf_a <= 10'h1 << sa;
        at(520);
        chk("four a trip", safe_a, 1'b0);
        complete_run();
    end
endmodule
